// *** design/branch_call_return_decode.sv ***
/*
 * branch, call and return execution for a 4-bit core, with an
 * ahb-lite register slave for control, flags and status.
 * assumes program memory answers prog_addr combinationally within the
 * cycle, and that interrupt take pulses come from the same clock.
 */
// Implementation choices: the register addresses and the AHB-Lite register port.
// Overview of operation
// (RULE_01) carry set: pc becomes next address plus displacement, one cycle.
// (RULE_02) carry clear: branch to next address plus displacement.
// (RULE_03) zero set: branch to next address plus displacement.
// (RULE_04) zero clear: branch to next address plus displacement.
// (RULE_05) less-or-equal branch taken when carry or zero set, else fall through.
// (RULE_06) greater branch taken only when carry and zero both clear.
// (RULE_07) extra flag clear branches; no conditional branch changes a flag.
// (RULE_08) far call pushes pc, loads 15-bit target, sp plus one, two cycles.
// (RULE_09) near call pushes pc, replaces pc bits 11..0, sp plus one.
// (RULE_10) return loads stacked value plus one, sp minus one, one cycle.
// (RULE_11) interrupt return acts as return and sets the interrupt enable.
// (RULE_12) nonmaskable return restores the enable saved at nonmaskable interrupt entry.
// (RULE_13) displacement is a signed two's-complement byte.
// (RULE_14) enable op sets, mask op clears the interrupt enable, one cycle.
`timescale 1ns/1ns
`include "bcr_regs.svh"

module branch_call_return_decode (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic      [`PC_W-1:0]    prog_addr,
    input  wire logic [15:0]         prog_data,
    input  wire logic                irq_take,
    input  wire logic                nmi_take,
    input  wire logic [`PC_W-1:0]    irq_vector,
    output logic                     master_irq_enable
);

    bcr_pkg::flags_t    flags_reg;
    bcr_pkg::state_t    state_reg;
    bcr_pkg::op_t       cur_op;
    logic [`PC_W-1:0]   pc_reg;
    logic [`PC_W-1:0]   pc_next;
    logic               run_reg;
    logic               mie_reg;
    logic               mie_saved_reg;
    logic               ovf_reg;
    logic               unf_reg;
    logic               wr_pend_reg;
    logic [7:0]         addr_q_reg;
    logic [31:0]        hrdata_reg;
    logic [31:0]        rd_next;
    logic               addr_phase;
    logic               exec_now;
    logic               take_now;
    logic               push;
    logic               pop;
    logic [`PC_W-1:0]   push_data;
    logic [`PC_W-1:0]   top_data;
    logic [`SP_W-1:0]   sp;
    logic               full;
    logic               empty;
    logic [`PC_W-1:0]   rel_target;
    logic               ovf_set;
    logic               unf_set;
    logic               bus_wr_stat;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    function automatic bcr_pkg::op_t decode_op(input logic [15:0] w);
        bcr_pkg::op_t op;
        op = bcr_pkg::OP_OTHER;
        if (w[15:12] == 4'h0 && w[11] && (w[10:9] != 2'b00 || !w[7]))
            op = bcr_pkg::OP_BRANCH;
        else if (w[15:12] == `NEAR_CALL_PFX)
            op = bcr_pkg::OP_NEAR_CALL;
        else if (w == `OPC_FAR_CALL)
            op = bcr_pkg::OP_FAR_CALL;
        else if (w == `OPC_RET)
            op = bcr_pkg::OP_RET;
        else if (w == `OPC_IRET)
            op = bcr_pkg::OP_IRET;
        else if (w == `OPC_NMRET)
            op = bcr_pkg::OP_NMRET;
        else if (w == `OPC_IRQ_EN)
            op = bcr_pkg::OP_IRQ_EN;
        else if (w == `OPC_IRQ_MASK)
            op = bcr_pkg::OP_IRQ_MASK;
        return op;
    endfunction : decode_op

    function automatic logic branch_cond(input logic [15:0] w,
                                         input bcr_pkg::flags_t f);
        logic t;
        t = 1'b0;
        case (w[10:9])
            `COND_CARRY: t = w[7] ? !f.c : f.c;                // RULE_01
            `COND_ZERO:  t = w[7] ? !f.z : f.z;        // RULE_03 RULE_04
            `COND_CZ:    t = (f.c | f.z) ^ w[7];       // RULE_05 RULE_06
            default:     t = !f.g;                             // RULE_07
        endcase
        return t;
    endfunction : branch_cond

    assign cur_op     = decode_op(prog_data);
    assign take_now   = run_reg && state_reg == bcr_pkg::ST_EXEC &&
                        (irq_take || nmi_take);
    assign exec_now   = run_reg && state_reg == bcr_pkg::ST_EXEC &&
                        !irq_take && !nmi_take;
    // signed byte, bit 8 of the word is the sign
    assign rel_target = pc_reg + `PC_W'(1) +
                        {{7{prog_data[8]}}, prog_data[8],
                         prog_data[6:0]};                      // RULE_13

    // ---------------------------------------------------------------
    // return stack
    // ---------------------------------------------------------------
    always_comb begin
        push      = 1'b0;
        pop       = 1'b0;
        push_data = pc_reg;
        if (take_now) begin
            push      = 1'b1;
            push_data = pc_reg - `PC_W'(1);
        end else if (state_reg == bcr_pkg::ST_FAR_2) begin
            push = 1'b1;                                       // RULE_08
        end else if (exec_now) begin
            case (cur_op)
                bcr_pkg::OP_NEAR_CALL: push = 1'b1;            // RULE_09
                bcr_pkg::OP_RET,
                bcr_pkg::OP_IRET,
                bcr_pkg::OP_NMRET:     pop = 1'b1;             // RULE_10
                default:               pop = 1'b0;
            endcase
        end
    end

    assign ovf_set = push && full;
    assign unf_set = pop && empty;

    return_stack u_stack (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .push      (push),
        .pop       (pop),
        .push_data (push_data),
        .top_data  (top_data),
        .sp        (sp),
        .full      (full),
        .empty     (empty)
    );

    // ---------------------------------------------------------------
    // program counter
    // ---------------------------------------------------------------
    always_comb begin
        pc_next = pc_reg;
        if (take_now) begin
            pc_next = irq_vector;
        end else if (state_reg == bcr_pkg::ST_FAR_2) begin
            pc_next = prog_data[`PC_W-1:0];                    // RULE_08
        end else if (exec_now) begin
            case (cur_op)
                bcr_pkg::OP_BRANCH:
                    pc_next = branch_cond(prog_data, flags_reg) ?
                              rel_target : pc_reg + `PC_W'(1); // RULE_02
                bcr_pkg::OP_NEAR_CALL:
                    pc_next = {pc_reg[`PC_W-1:12],
                               prog_data[11:0]};               // RULE_09
                bcr_pkg::OP_RET,
                bcr_pkg::OP_IRET,
                bcr_pkg::OP_NMRET:
                    pc_next = empty ? pc_reg + `PC_W'(1) :
                              top_data + `PC_W'(1);            // RULE_10
                default:
                    pc_next = pc_reg + `PC_W'(1);
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_reg <= `PC_RST;
        end else if (wr_pend_reg && addr_q_reg == `ADDR_PC && !run_reg) begin
            pc_reg <= hwdata[`PC_W-1:0];
        end else begin
            pc_reg <= pc_next;
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= bcr_pkg::ST_EXEC;
        end else begin
            case (state_reg)
                bcr_pkg::ST_EXEC:
                    if (exec_now && cur_op == bcr_pkg::OP_FAR_CALL) begin
                        state_reg <= bcr_pkg::ST_FAR_2;        // RULE_08
                    end
                bcr_pkg::ST_FAR_2:
                    state_reg <= bcr_pkg::ST_EXEC;
                default:
                    state_reg <= bcr_pkg::ST_EXEC;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // master interrupt enable
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mie_reg       <= `MIE_RST;
            mie_saved_reg <= `MIE_RST;
        end else if (take_now) begin
            mie_reg <= 1'b0;
            if (nmi_take) begin
                mie_saved_reg <= mie_reg;                      // RULE_12
            end
        end else if (exec_now) begin
            case (cur_op)
                bcr_pkg::OP_IRET:      mie_reg <= 1'b1;        // RULE_11
                bcr_pkg::OP_NMRET:     mie_reg <= mie_saved_reg; // RULE_12
                bcr_pkg::OP_IRQ_EN:    mie_reg <= 1'b1;        // RULE_14
                bcr_pkg::OP_IRQ_MASK:  mie_reg <= 1'b0;        // RULE_14
                default:               mie_reg <= mie_reg;
            endcase
        end
    end

    assign master_irq_enable = mie_reg;
    assign prog_addr         = pc_reg;

    // ---------------------------------------------------------------
    // ahb-lite slave
    // ---------------------------------------------------------------
    assign addr_phase  = hsel && htrans[1] && hready;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = hrdata_reg;
    assign bus_wr_stat = wr_pend_reg && addr_q_reg == `ADDR_STAT;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_q_reg  <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            addr_q_reg  <= haddr[7:0];
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        case (haddr[7:0])
            `ADDR_CTRL:  rd_next[`CTRL_RUN_BIT] = run_reg;
            `ADDR_FLAGS: rd_next[2:0] = flags_reg;
            `ADDR_PC:    rd_next[`PC_W-1:0] = pc_reg;
            `ADDR_STAT: begin
                rd_next[`SP_W-1:0]          = sp;
                rd_next[`STAT_MIE_BIT]       = mie_reg;
                rd_next[`STAT_MIE_SAVED_BIT] = mie_saved_reg;
                rd_next[`STAT_OVF_BIT]       = ovf_reg;
                rd_next[`STAT_UNF_BIT]       = unf_reg;
            end
            default:     rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata_reg <= rd_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_reg <= 1'b0;
        end else if (wr_pend_reg && addr_q_reg == `ADDR_CTRL) begin
            run_reg <= hwdata[`CTRL_RUN_BIT];
        end
    end

    // flags change only by bus write, never by a branch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= `FLAGS_RST;
        end else if (wr_pend_reg && addr_q_reg == `ADDR_FLAGS) begin
            flags_reg <= hwdata[2:0];                          // RULE_07
        end
    end

    // sticky errors, write one to clear, a new event wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_reg <= 1'b0;
            unf_reg <= 1'b0;
        end else begin
            ovf_reg <= (ovf_reg & !(bus_wr_stat && hwdata[`STAT_OVF_BIT]))
                       | ovf_set;
            unf_reg <= (unf_reg & !(bus_wr_stat && hwdata[`STAT_UNF_BIT]))
                       | unf_set;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_BR_CARRY: assert property (                            // RULE_01
        (exec_now && cur_op == bcr_pkg::OP_BRANCH &&
         prog_data[10:9] == 2'b01 && !prog_data[7] && flags_reg.c)
        |=> pc_reg == $past(pc_reg) + `PC_W'(1) +
            {{8{$past(prog_data[8])}}, $past(prog_data[6:0])})
        else $error("carry branch target wrong");

    AST_BR_NO_CARRY: assert property (                         // RULE_02
        (exec_now && cur_op == bcr_pkg::OP_BRANCH &&
         prog_data[10:9] == 2'b01 && prog_data[7])
        |=> pc_reg == ($past(flags_reg.c) ? $past(pc_reg) + `PC_W'(1)
                       : $past(rel_target)))
        else $error("no-carry branch wrong");

    AST_BR_ZERO: assert property (                             // RULE_03
        (exec_now && cur_op == bcr_pkg::OP_BRANCH &&
         prog_data[10:9] == 2'b10 && !prog_data[7] && !flags_reg.z)
        |=> pc_reg == $past(pc_reg) + `PC_W'(1))
        else $error("zero branch taken with zero clear");

    AST_BR_NOT_ZERO: assert property (                         // RULE_04
        (exec_now && cur_op == bcr_pkg::OP_BRANCH &&
         prog_data[10:9] == 2'b10 && prog_data[7] && !flags_reg.z)
        |=> pc_reg == $past(rel_target))
        else $error("not-zero branch not taken");

    AST_BR_LE: assert property (                               // RULE_05
        (exec_now && cur_op == bcr_pkg::OP_BRANCH &&
         prog_data[10:9] == 2'b11 && !prog_data[7] &&
         (flags_reg.c || flags_reg.z))
        |=> pc_reg == $past(rel_target))
        else $error("less-or-equal branch not taken");

    AST_BR_GT: assert property (                               // RULE_06
        (exec_now && cur_op == bcr_pkg::OP_BRANCH &&
         prog_data[10:9] == 2'b11 && prog_data[7] &&
         (flags_reg.c || flags_reg.z))
        |=> pc_reg == $past(pc_reg) + `PC_W'(1))
        else $error("greater branch taken with a flag set");

    AST_FLAGS_HOLD: assert property (                          // RULE_07
        !(wr_pend_reg && addr_q_reg == `ADDR_FLAGS)
        |=> $stable(flags_reg))
        else $error("flags changed without a bus write");

    AST_FAR_CALL: assert property (                            // RULE_08
        (exec_now && cur_op == bcr_pkg::OP_FAR_CALL && sp < `SP_W'(7))
        |=> state_reg == bcr_pkg::ST_FAR_2
        ##1 (pc_reg == $past(prog_data[`PC_W-1:0]) &&
             sp == $past(sp, 2) + `SP_W'(1)))
        else $error("far call wrong");

    AST_NEAR_CALL: assert property (                           // RULE_09
        (exec_now && cur_op == bcr_pkg::OP_NEAR_CALL && !full)
        |=> pc_reg == {$past(pc_reg[`PC_W-1:12]), $past(prog_data[11:0])}
            && sp == $past(sp) + `SP_W'(1))
        else $error("near call wrong");

    AST_RETURN: assert property (                              // RULE_10
        (exec_now && cur_op == bcr_pkg::OP_RET && !empty)
        |=> pc_reg == $past(top_data) + `PC_W'(1) &&
            sp == $past(sp) - `SP_W'(1))
        else $error("return wrong");

    AST_IRET_MIE: assert property (                            // RULE_11
        (exec_now && cur_op == bcr_pkg::OP_IRET) |=> mie_reg)
        else $error("interrupt return left enable clear");

    AST_NMRET_MIE: assert property (                           // RULE_12
        (exec_now && cur_op == bcr_pkg::OP_NMRET)
        |=> mie_reg == $past(mie_saved_reg))
        else $error("nonmaskable return did not restore enable");

    AST_EI_DI: assert property (                               // RULE_14
        (exec_now && (cur_op == bcr_pkg::OP_IRQ_EN ||
                      cur_op == bcr_pkg::OP_IRQ_MASK))
        |=> mie_reg == ($past(cur_op) == bcr_pkg::OP_IRQ_EN))
        else $error("enable or mask op wrong");

endmodule : branch_call_return_decode

// *** design/bcr_regs.svh ***
/*
 * register offsets, field positions, reset values and opcode encodings
 * of the branch, call and return decoder.
 * assumes inclusion by bare name from the design files.
 */
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ADDR_CTRL          8'h00
`define ADDR_FLAGS         8'h04
`define ADDR_PC            8'h08
`define ADDR_STAT          8'h0c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_RUN_BIT       0
`define FLAG_C_BIT         0
`define FLAG_Z_BIT         1
`define FLAG_G_BIT         2
`define STAT_MIE_BIT       8
`define STAT_MIE_SAVED_BIT 9
`define STAT_OVF_BIT       16
`define STAT_UNF_BIT       17

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define PC_W               15
`define SP_W               4
`define STACK_DEPTH        8
`define PC_RST             15'h0000
`define FLAGS_RST          3'h0
`define MIE_RST            1'b0

// ---------------------------------------------------------------
// opcode encodings
// ---------------------------------------------------------------
`define OPC_FAR_CALL       16'h0015
`define OPC_RET            16'h000b
`define OPC_IRET           16'h000c
`define OPC_NMRET          16'h000d
`define OPC_IRQ_EN         16'h000e
`define OPC_IRQ_MASK       16'h0007
`define NEAR_CALL_PFX      4'hf
`define COND_EXTRA         2'b00
`define COND_CARRY         2'b01
`define COND_ZERO          2'b10
`define COND_CZ            2'b11

`endif

// *** design/bcr_pkg.sv ***
/*
 * types shared by the branch, call and return decoder.
 * assumes nothing of its surroundings.
 */
package bcr_pkg;

    typedef struct packed {
        logic g;
        logic z;
        logic c;
    } flags_t;

    typedef enum logic [3:0] {
        OP_BRANCH,
        OP_FAR_CALL,
        OP_NEAR_CALL,
        OP_RET,
        OP_IRET,
        OP_NMRET,
        OP_IRQ_EN,
        OP_IRQ_MASK,
        OP_OTHER
    } op_t;

    typedef enum logic {
        ST_EXEC,
        ST_FAR_2
    } state_t;

endpackage : bcr_pkg

// *** design/return_stack.sv ***
/*
 * return address stack held in flip-flops.
 * assumes push and pop never arrive in the same cycle.
 */
`timescale 1ns/1ns
`include "bcr_regs.svh"

module return_stack (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 push,
    input  wire logic                 pop,
    input  wire logic [`PC_W-1:0]     push_data,
    output logic      [`PC_W-1:0]     top_data,
    output logic      [`SP_W-1:0]     sp,
    output logic                      full,
    output logic                      empty
);

    logic [`PC_W-1:0] entry_reg [`STACK_DEPTH];
    logic [`SP_W-1:0] sp_reg;
    logic [`SP_W-1:0] top_idx;

    assign full     = (sp_reg == `SP_W'(`STACK_DEPTH));
    assign empty    = (sp_reg == `SP_W'(0));
    assign sp       = sp_reg;
    assign top_idx  = sp_reg - `SP_W'(1);
    assign top_data = entry_reg[top_idx[`SP_W-2:0]];

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    for (genvar i = 0; i < `STACK_DEPTH; i++) begin : g_entry
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                entry_reg[i] <= `PC_RST;
            end else if (push && !full && sp_reg == `SP_W'(i)) begin
                entry_reg[i] <= push_data;
            end
        end
    end

    // ---------------------------------------------------------------
    // pointer
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_reg <= `SP_W'(0);
        end else if (push && !full) begin
            sp_reg <= sp_reg + `SP_W'(1);
        end else if (pop && !empty) begin
            sp_reg <= sp_reg - `SP_W'(1);
        end
    end

endmodule : return_stack

// *** sim/prog_rom.sv ***
/*
 * program memory model answering the instruction fetch port.
 * assumes the bench fills mem by hierarchical reference while halted.
 */
`timescale 1ns/1ns

module prog_rom (
    input  wire logic [14:0] addr,
    output logic      [15:0] data
);
    logic [15:0] mem [0:32767];

    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
    end

    // combinational read, same cycle as the address
    assign data = mem[addr];
endmodule : prog_rom

// *** sim/branch_call_return_decode_tb.sv ***
/*
 * self-checking bench: branches, calls, returns, enable ops, registers.
 * assumes zero-wait bus slave and combinational program memory.
 */
`timescale 1ns/1ns

module branch_call_return_decode_tb;
    logic        hclk, hresetn, hsel, hwrite, nmi_take;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, cc;
    logic [2:0]  hsize, fl;
    logic [14:0] prog_addr, irq_vector, p, t, e;
    logic [15:0] prog_data;
    logic        hreadyout, hresp, master_irq_enable, pol, tk;
    logic [7:0]  d;
    int          bad_count, cmp_count;

    branch_call_return_decode dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .prog_addr(prog_addr), .prog_data(prog_data), .irq_take(1'b0),
        .nmi_take(nmi_take), .irq_vector(irq_vector),
        .master_irq_enable(master_irq_enable));
    prog_rom rom (.addr(prog_addr), .data(prog_data));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb

    task automatic chk(input logic [31:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // run from p until k changes of fetch address are seen, then halt
    task automatic go(input int k, input logic [14:0] x);
        int n, c;
        logic [14:0] pv;
        n = 0;
        c = 0;
        ahb(1'b1, 8'h08, {17'h0, p}, rd);
        ahb(1'b1, 8'h00, 32'h1, rd);
        @(negedge hclk);
        pv = prog_addr;
        while (c < k && n < 20) begin
            @(negedge hclk);
            n++;
            if (prog_addr !== pv) c++;
            pv = prog_addr;
        end
        chk({17'h0, prog_addr}, {17'h0, x}, "pc");
        ahb(1'b1, 8'h00, 32'h0, rd);
    endtask : go

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    initial begin
        #160000;
        bad_count++;
        finish_test();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; nmi_take = 1'b0;
        irq_vector = 15'h0;
        void'($urandom(63436));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b1, 8'h10, 32'hffffffff, rd);
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, 8'(i * 4), 32'h0, rd);
            chk(rd, 32'h0, "reset or unmapped");
        end
        chk({31'h0, hresp}, 32'h0, "resp");
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            cc = 2'($urandom);
            pol = (cc == 2'b00) ? 1'b0 : 1'($urandom);
            fl = 3'($urandom);
            d = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($urandom);
            if (d == 8'hff) d = 8'hfe;
            p = 15'($urandom_range(16'h0100, 16'h6000));
            ahb(1'b1, 8'h04, {29'h0, fl}, rd);
            rom.mem[p] = {4'h0, 1'b1, cc, d[7], pol, d[6:0]};
            tk = (cc == 2'b00) ? !fl[2] : ((cc == 2'b01) ? fl[0] :
                 (cc == 2'b10) ? fl[1] : (fl[0] | fl[1])) ^ pol;
            go(1, tk ? p + 15'd1 + {{7{d[7]}}, d} : p + 15'd1);
            ahb(1'b0, 8'h04, 32'h0, rd);
            chk(rd, {29'h0, fl}, "flags");
            rom.mem[p] = 16'h0000;
        end
        $display("test branches done");
        for (int i = 0; i < 3; i++) begin
            p = 15'($urandom_range(16'h0100, 16'h6000));
            rom.mem[p] = (i == 1) ? 16'h000e : 16'h0007;
            go(1, p + 15'd1);
            chk({31'h0, master_irq_enable}, {31'h0, i == 1}, "en");
            rom.mem[p] = 16'h0000;
        end
        t = {p[14:12], p[11:0] ^ 12'h800};
        rom.mem[p] = {4'hf, t[11:0]};
        rom.mem[t] = 16'h000b;
        go(2, p + 15'd1);
        rom.mem[p] = 16'h0015;
        rom.mem[p + 15'd1] = {1'b0, t};
        rom.mem[t] = 16'h000c;
        go(3, p + 15'd2);
        chk({31'h0, master_irq_enable}, 32'h1, "iret en");
        rom.mem[p] = 16'h0000;
        rom.mem[p + 15'd1] = 16'h0000;
        rom.mem[t] = 16'h000d;
        // enable held 1 then 0 before entry: the return must restore each
        for (int k = 0; k < 2; k++) begin
            rom.mem[p] = k ? 16'h0007 : 16'h0000;
            go(1, p + 15'd1);
            ahb(1'b1, 8'h08, {17'h0, p}, rd);
            ahb(1'b1, 8'h00, 32'h1, rd);
            nmi_take <= 1'b1;
            irq_vector <= t;
            @(posedge hclk);
            nmi_take <= 1'b0;
            @(negedge hclk);
            chk({16'h0, master_irq_enable, prog_addr}, {17'h0, t}, "entry");
            @(negedge hclk);
            chk({16'h0, master_irq_enable, prog_addr}, {16'h0, k == 0, p},
                "nmret");
            ahb(1'b1, 8'h00, 32'h0, rd);
        end
        ahb(1'b0, 8'h0c, 32'h0, rd);
        chk({28'h0, rd[3:0]}, 32'h0, "sp");
        $display("test calls and returns done");
        finish_test();
    end
endmodule : branch_call_return_decode_tb
